/* logic/mlc_pkg.sv */
package mlc_pkg;

  localparam int NSRC = 4;
  localparam int LIM_W = 16;
  localparam int ADDR_W = 8;

  // limit values are signed hundredths of a dB (or dBm)
  typedef logic signed [LIM_W-1:0] mlc_lim_t;

  // byte offsets of the registers
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_FLAG = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_UPPER = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_LOWER = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_OUT0 = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_OUT1 = 8'h44;
  localparam logic [ADDR_W-1:0] OFS_BANK_MASK = 8'hf3;
  localparam logic [ADDR_W-1:0] OFS_IDX_MASK = 8'h0c;
  localparam int IDX_LSB = 2;

  // field positions
  localparam int CTRL_EN_LSB = 0;
  localparam int CTRL_UNIT_LSB = 4;
  localparam int OUT_EN_BIT = 0;
  localparam int OUT_POL_BIT = 1;
  localparam int OUT_KIND_LSB = 2;
  localparam int OUT_WIN_LSB = 4;
  localparam int OUT_CFG_W = 6;

  // sources 0 and 1 are channels, 2 and 3 are the two display windows
  localparam int WIN1_IDX = 2;
  localparam int WIN2_IDX = 3;

  // reset values of the output configuration: off, active high, either kind, window 1
  localparam logic [OUT_CFG_W-1:0] OUT_CFG_RST = 6'h1e;

  // spans and defaults in dBm units
  localparam mlc_lim_t DBM_MAX = 16'sh59d8;
  localparam mlc_lim_t DBM_MIN = 16'shc568;
  localparam mlc_lim_t DBM_DEF_UP = 16'sh2328;
  localparam mlc_lim_t DBM_DEF_LO = 16'shdcd8;
  // spans and defaults in dB (ratio) units
  localparam mlc_lim_t DB_MAX = 16'sh4e20;
  localparam mlc_lim_t DB_MIN = 16'shb9b0;
  localparam mlc_lim_t DB_DEF_UP = 16'sh1770;
  localparam mlc_lim_t DB_DEF_LO = 16'shd120;

  function automatic mlc_lim_t lim_clamp(input mlc_lim_t v, input logic db);
    mlc_lim_t hi;
    mlc_lim_t lo;
    hi = db ? DB_MAX : DBM_MAX;
    lo = db ? DB_MIN : DBM_MIN;
    if (v > hi) return hi;
    if (v < lo) return lo;
    return v;
  endfunction : lim_clamp

  function automatic mlc_lim_t lim_default(input logic upper, input logic db);
    if (upper) return db ? DB_DEF_UP : DBM_DEF_UP;
    return db ? DB_DEF_LO : DBM_DEF_LO;
  endfunction : lim_default

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) r[b*8 +: 8] = new_v[b*8 +: 8];
    end
    return r;
  endfunction : be_merge

endpackage : mlc_pkg

/* logic/mlc_limit_cmp.sv */
`timescale 1ns/1ps
module mlc_limit_cmp #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic meas_valid_i, // result for this source
  input wire mlc_pkg::mlc_lim_t meas_value_i, // result value
  input wire mlc_pkg::mlc_lim_t upper_i, // upper bound
  input wire mlc_pkg::mlc_lim_t lower_i, // lower bound
  input wire logic check_en_i, // limit checking on
  input wire logic clear_i, // clear flag and count
  output logic over_o, // last result above upper
  output logic under_o, // last result below lower
  output logic flag_o, // any failure since clear
  output logic [CNT_W-1:0] count_o, // failures since clear
  output logic fail_o // one-cycle failure event
);
  import mlc_pkg::*;

  logic chk;
  logic over_d;
  logic under_d;
  assign chk = meas_valid_i && check_en_i;
  assign over_d = meas_value_i > upper_i;
  assign under_d = meas_value_i < lower_i;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i || !check_en_i) begin
      over_o <= 1'b0;
      under_o <= 1'b0;
    end else if (meas_valid_i) begin
      over_o <= over_d;
      under_o <= under_d;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) fail_o <= 1'b0;
    else fail_o <= chk && (over_d || under_d);
  end

  // a failure in the clearing cycle wins over the clear
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) flag_o <= 1'b0;
    else if (chk && (over_d || under_d)) flag_o <= 1'b1;
    else if (clear_i) flag_o <= 1'b0;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      count_o <= '0;
    end else if (chk && (over_d || under_d)) begin
      if (clear_i) count_o <= CNT_W'(1);
      else if (count_o != {CNT_W{1'b1}}) count_o <= count_o + CNT_W'(1);
    end else if (clear_i) begin
      count_o <= '0;
    end
  end

  a_count_saturates: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (count_o == {CNT_W{1'b1}}) && !clear_i |=> (count_o == {CNT_W{1'b1}}))
    else $error("failure count wrapped");

  a_flag_on_fail: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    chk && meas_value_i > upper_i |=> flag_o && fail_o && over_o)
    else $error("over-limit result did not raise flag");

  a_under_detect: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    chk && meas_value_i < lower_i |=> under_o && count_o != '0)
    else $error("under-limit result not counted");

endmodule : mlc_limit_cmp

/* logic/mlc_limit_out.sv */
`timescale 1ns/1ps
module mlc_limit_out (
  input wire logic sys_clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic [mlc_pkg::OUT_CFG_W-1:0] cfg_i, // enable, polarity, kind, window
  input wire logic [1:0] win_en_i, // checking on for window 1 and 2
  input wire logic [1:0] win_over_i, // over state of window 1 and 2
  input wire logic [1:0] win_under_i, // under state of window 1 and 2
  output logic level_o // logic-level pin
);
  import mlc_pkg::*;

  logic en;
  logic act_high;
  logic [1:0] kind;
  logic [1:0] wsel;
  logic [1:0] hit;
  logic active;

  assign en = cfg_i[OUT_EN_BIT];
  assign act_high = cfg_i[OUT_POL_BIT];
  assign kind = cfg_i[OUT_KIND_LSB +: 2];
  assign wsel = cfg_i[OUT_WIN_LSB +: 2];
  // kind bit 0 selects over, bit 1 under; window bit n selects window n+1
  assign hit = win_en_i & ((win_over_i & {2{kind[0]}}) | (win_under_i & {2{kind[1]}}));
  assign active = en && |(hit & wsel);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) level_o <= !OUT_CFG_RST[OUT_POL_BIT];
    else level_o <= act_high ? active : !active;
  end

  a_out_off_idle: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !en ##1 $stable(cfg_i) |-> level_o == !act_high)
    else $error("disabled output not at idle level");

  a_out_polarity: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    active ##1 $stable(cfg_i) |-> level_o == act_high)
    else $error("output not at its active level");

endmodule : mlc_limit_out

/* logic/mlc_limit_checker.sv */
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ps
//Contract
// - fail when result outside enabled bounds
// - limits span -150 to +230 dBm
// - power limits reset to +90/-90 dBm
// - span and defaults follow line unit
// - dB windows: -180..+200, defaults 60/-120
// - separate checks per channel and window
// - each logic output has own enable
// - each logic output polarity selectable
// - output asserts on over, under, either
// - output follows window 1, 2, either
// - flag reads one after any failure
// - count all failures, readable total (count saturates at its CNT_W-bit maximum)
// - failure raises status event, interrupt
module mlc_limit_checker #(
  parameter int CNT_W = 16
) (
  input wire logic sys_clk_i, // clock, 10 MHz
  input wire logic nrst_i, // sync reset, active low
  input wire logic [mlc_pkg::ADDR_W-1:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read request
  input wire logic avs_write_i, // write request
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  input wire logic meas_valid_i, // completed result pulse
  input wire logic [1:0] meas_src_i, // 0,1 channel, 2,3 window
  input wire mlc_pkg::mlc_lim_t meas_value_i, // result, hundredths of dB
  output logic limit_output_one_o, // first logic-level output
  output logic limit_output_two_o, // second logic-level output
  output logic irq_o // level interrupt
);
  import mlc_pkg::*;

  logic ack_q;
  logic [31:0] rdata_q;
  logic wr_fire;
  logic [ADDR_W-1:0] bank;
  logic [1:0] idx;
  logic [NSRC-1:0] bound_check_enable_q;
  logic [NSRC-1:0] unit_db_q;
  mlc_lim_t upper_bound_setting_q [NSRC];
  mlc_lim_t lower_bound_setting_q [NSRC];
  logic [NSRC-1:0] irq_stat_q;
  logic [NSRC-1:0] irq_mask_q;
  logic [OUT_CFG_W-1:0] out_cfg_q [2];
  logic [NSRC-1:0] clear_d;
  logic [NSRC-1:0] over;
  logic [NSRC-1:0] under;
  logic [NSRC-1:0] flag;
  logic [NSRC-1:0] fail;
  logic [CNT_W-1:0] failure_count_query [NSRC];
  logic [31:0] ctrl_wr;
  logic [31:0] lim_wr;
  logic [31:0] low_wr;

  // bus slave: every request is held off for one cycle, answered on the next
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_q;
  assign wr_fire = avs_write_i && !avs_waitrequest_o;
  assign bank = avs_address_i & OFS_BANK_MASK;
  assign idx = avs_address_i[IDX_LSB +: 2];
  assign avs_readdata_o = rdata_q;

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) ack_q <= 1'b0;
    else ack_q <= (avs_read_i || avs_write_i) && !ack_q;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (avs_read_i && !ack_q) begin
      rdata_q <= 32'h0000_0000;
      case (avs_address_i)
        OFS_CTRL: rdata_q <= {24'h00_0000, unit_db_q, bound_check_enable_q};
        OFS_IRQ_STAT: rdata_q <= {28'h000_0000, irq_stat_q};
        OFS_IRQ_MASK: rdata_q <= {28'h000_0000, irq_mask_q};
        OFS_FLAG: rdata_q <= {28'h000_0000, flag};
        OFS_OUT0: rdata_q <= {26'h000_0000, out_cfg_q[0]};
        OFS_OUT1: rdata_q <= {26'h000_0000, out_cfg_q[1]};
        default: begin
          if (bank == OFS_UPPER) begin
            rdata_q <= {{16{upper_bound_setting_q[idx][LIM_W-1]}}, upper_bound_setting_q[idx]};
          end else if (bank == OFS_LOWER) begin
            rdata_q <= {{16{lower_bound_setting_q[idx][LIM_W-1]}}, lower_bound_setting_q[idx]};
          end else if (bank == OFS_COUNT) begin
            rdata_q <= 32'(failure_count_query[idx]);
          end
        end
      endcase
    end
  end

  assign ctrl_wr = be_merge({24'h00_0000, unit_db_q, bound_check_enable_q},
                            avs_writedata_i, avs_byteenable_i);
  assign lim_wr = be_merge({{16{upper_bound_setting_q[idx][LIM_W-1]}},
                            upper_bound_setting_q[idx]}, avs_writedata_i, avs_byteenable_i);
  assign low_wr = be_merge({{16{lower_bound_setting_q[idx][LIM_W-1]}},
                            lower_bound_setting_q[idx]}, avs_writedata_i, avs_byteenable_i);

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      bound_check_enable_q <= '0;
      unit_db_q <= '0;
    end else if (wr_fire && avs_address_i == OFS_CTRL) begin
      bound_check_enable_q <= ctrl_wr[CTRL_EN_LSB +: NSRC];
      unit_db_q <= ctrl_wr[CTRL_UNIT_LSB +: NSRC];
    end
  end

  // limits reset to dBm defaults; a unit change reloads that unit's defaults
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < NSRC; i++) begin
        upper_bound_setting_q[i] <= DBM_DEF_UP;
        lower_bound_setting_q[i] <= DBM_DEF_LO;
      end
    end else if (wr_fire) begin
      if (avs_address_i == OFS_CTRL) begin
        for (int i = 0; i < NSRC; i++) begin
          if (ctrl_wr[CTRL_UNIT_LSB + i] != unit_db_q[i]) begin
            upper_bound_setting_q[i] <= lim_default(1'b1, ctrl_wr[CTRL_UNIT_LSB + i]);
            lower_bound_setting_q[i] <= lim_default(1'b0, ctrl_wr[CTRL_UNIT_LSB + i]);
          end
        end
      end else if (bank == OFS_UPPER) begin
        upper_bound_setting_q[idx] <= lim_clamp(lim_wr[LIM_W-1:0], unit_db_q[idx]);
      end else if (bank == OFS_LOWER) begin
        lower_bound_setting_q[idx] <= lim_clamp(low_wr[LIM_W-1:0], unit_db_q[idx]);
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      out_cfg_q[0] <= OUT_CFG_RST;
      out_cfg_q[1] <= OUT_CFG_RST;
    end else if (wr_fire && avs_byteenable_i[0]) begin
      if (avs_address_i == OFS_OUT0) out_cfg_q[0] <= avs_writedata_i[OUT_CFG_W-1:0];
      if (avs_address_i == OFS_OUT1) out_cfg_q[1] <= avs_writedata_i[OUT_CFG_W-1:0];
    end
  end

  // writing a one to a flag bit clears that source's flag and count
  assign clear_d = (wr_fire && avs_address_i == OFS_FLAG && avs_byteenable_i[0]) ?
                   avs_writedata_i[NSRC-1:0] : '0;

  // interrupt status: set by a failure, write one to clear, set wins
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      irq_stat_q <= '0;
    end else begin
      if (wr_fire && avs_address_i == OFS_IRQ_STAT && avs_byteenable_i[0]) begin
        irq_stat_q <= (irq_stat_q & ~avs_writedata_i[NSRC-1:0]) | fail;
      end else begin
        irq_stat_q <= irq_stat_q | fail;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) irq_mask_q <= '0;
    else if (wr_fire && avs_address_i == OFS_IRQ_MASK && avs_byteenable_i[0]) begin
      irq_mask_q <= avs_writedata_i[NSRC-1:0];
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // one independent checker per channel and per window
  for (genvar g = 0; g < NSRC; g++) begin : g_src
    mlc_limit_cmp #(.CNT_W(CNT_W)) u_cmp (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .meas_valid_i(meas_valid_i && meas_src_i == 2'(g)),
      .meas_value_i(meas_value_i),
      .upper_i(upper_bound_setting_q[g]),
      .lower_i(lower_bound_setting_q[g]),
      .check_en_i(bound_check_enable_q[g]),
      .clear_i(clear_d[g]),
      .over_o(over[g]),
      .under_o(under[g]),
      .flag_o(flag[g]),
      .count_o(failure_count_query[g]),
      .fail_o(fail[g])
    );
  end

  mlc_limit_out u_out_one (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .cfg_i(out_cfg_q[0]),
    .win_en_i({bound_check_enable_q[WIN2_IDX], bound_check_enable_q[WIN1_IDX]}),
    .win_over_i({over[WIN2_IDX], over[WIN1_IDX]}),
    .win_under_i({under[WIN2_IDX], under[WIN1_IDX]}),
    .level_o(limit_output_one_o)
  );

  mlc_limit_out u_out_two (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .cfg_i(out_cfg_q[1]),
    .win_en_i({bound_check_enable_q[WIN2_IDX], bound_check_enable_q[WIN1_IDX]}),
    .win_over_i({over[WIN2_IDX], over[WIN1_IDX]}),
    .win_under_i({under[WIN2_IDX], under[WIN1_IDX]}),
    .level_o(limit_output_two_o)
  );

  a_bus_one_wait: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    (avs_read_i || avs_write_i) && !ack_q |=> !avs_waitrequest_o)
    else $error("bus request not answered after one wait cycle");

  a_irq_sticky: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    fail[WIN1_IDX] && irq_mask_q[WIN1_IDX] |=> irq_o && irq_stat_q[WIN1_IDX])
    else $error("failure did not raise the interrupt");

  a_limit_span: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !unit_db_q[0] |-> upper_bound_setting_q[0] <= DBM_MAX && upper_bound_setting_q[0] >= DBM_MIN)
    else $error("dBm upper limit outside its span");

  a_db_span: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    unit_db_q[WIN2_IDX] |-> lower_bound_setting_q[WIN2_IDX] >= DB_MIN &&
    lower_bound_setting_q[WIN2_IDX] <= DB_MAX)
    else $error("dB lower limit outside its span");

  a_reset_defaults: assert property (@(posedge sys_clk_i)
    !nrst_i |=> upper_bound_setting_q[1] == DBM_DEF_UP && lower_bound_setting_q[1] == DBM_DEF_LO)
    else $error("limits not at defaults after reset");

  a_unit_reload: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    $rose(unit_db_q[WIN2_IDX]) |-> upper_bound_setting_q[WIN2_IDX] == DB_DEF_UP &&
    lower_bound_setting_q[WIN2_IDX] == DB_DEF_LO)
    else $error("dB defaults not loaded on unit change");

  a_disabled_quiet: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
    !bound_check_enable_q[1] |=> !fail[1] && !over[1] && !under[1])
    else $error("disabled checker reported a failure");

endmodule : mlc_limit_checker

/* test/mlc_alarm_model.sv */
`timescale 1ns/1ps
// external alarm logic: counts the onsets of a failure shown on a logic-level pin
module mlc_alarm_model (
  input wire logic sys_clk_i, // clock
  input wire logic nrst_i, // sync reset, active low
  input wire logic level_i, // pin from the checker
  input wire logic active_high_i, // polarity the pin was set to
  output logic [7:0] onsets_o // failure onsets seen
);
  logic act_q;
  logic act_d;
  assign act_d = active_high_i ? level_i : ~level_i;
  always_ff @(posedge sys_clk_i) begin
    if (!nrst_i) begin
      act_q <= 1'b0;
      onsets_o <= 8'h00;
    end else begin
      act_q <= act_d;
      if (act_d && !act_q) onsets_o <= onsets_o + 8'h01;
    end
  end
endmodule : mlc_alarm_model

/* test/testbench.sv */
`timescale 1ns/1ps
module testbench;
  import mlc_pkg::*;
  localparam int CW = 3;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [ADDR_W-1:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [3:0] be = 4'hf;
  logic [31:0] rdat;
  logic wait_r;
  logic mv = 1'b0;
  logic [1:0] msrc = 2'h0;
  mlc_lim_t mval = 16'sh0000;
  logic out1;
  logic out2;
  logic irq;
  logic [7:0] onsets;
  logic pol1 = 1'b1;
  int n_errors = 0;
  int n_checks = 0;
  int cyc = 0;

  mlc_limit_checker #(.CNT_W(CW)) mlc_limit_checker_i (.sys_clk_i(clk), .nrst_i(nrst),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat), .avs_waitrequest_o(wait_r),
    .meas_valid_i(mv), .meas_src_i(msrc), .meas_value_i(mval),
    .limit_output_one_o(out1), .limit_output_two_o(out2), .irq_o(irq));
  mlc_alarm_model mlc_alarm_model_i (.sys_clk_i(clk), .nrst_i(nrst), .level_i(out1),
    .active_high_i(pol1), .onsets_o(onsets));

  always #50 clk = ~clk;

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 20000) begin
      n_errors++;
      close_out();
    end
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp

  // one bus cycle; the request stands until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    adr <= a;
    wdat <= d;
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (wait_r !== 1'b0) @(posedge clk);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task automatic wreg(input logic [7:0] a, input int v);
    logic [31:0] q;
    bus(1'b1, a, 32'(v), q);
    // let the write settle before pins are looked at
    #1;
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input int v);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    cmp(q, 32'(v), "register");
  endtask : rchk

  // result taken at the second edge; pins settle one edge later
  task automatic meas(input logic [1:0] s, input int v);
    @(posedge clk);
    mv <= 1'b1;
    msrc <= s;
    mval <= 16'(v);
    @(posedge clk);
    mv <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : meas

  task automatic t_reset;
    rchk(OFS_UPPER + 8'h08, 9000);
    rchk(OFS_LOWER + 8'h08, -9000);
    rchk(OFS_COUNT + 8'h08, 0);
    rchk(OFS_FLAG, 0);
    rchk(8'hf0, 0);
    cmp({29'h0, out1, out2, irq}, 32'h0, "pins after reset");
  endtask : t_reset

  task automatic t_units;
    wreg(OFS_CTRL, 'h80);
    rchk(OFS_UPPER + 8'h0c, 6000);
    rchk(OFS_LOWER + 8'h0c, -12000);
    wreg(OFS_UPPER + 8'h0c, 30000);
    rchk(OFS_UPPER + 8'h0c, 20000);
    wreg(OFS_LOWER + 8'h0c, -20000);
    rchk(OFS_LOWER + 8'h0c, -18000);
    wreg(OFS_UPPER + 8'h08, 30000);
    rchk(OFS_UPPER + 8'h08, 23000);
    wreg(OFS_LOWER + 8'h08, -16000);
    rchk(OFS_LOWER + 8'h08, -15000);
  endtask : t_units

  task automatic t_fail;
    wreg(OFS_UPPER + 8'h08, -1000);
    wreg(OFS_LOWER + 8'h08, -3000);
    wreg(OFS_CTRL, 'h8c);
    wreg(OFS_IRQ_MASK, 'h04);
    meas(2'd2, -2000);
    meas(2'd2, -1000);
    meas(2'd2, -3000);
    rchk(OFS_FLAG, 0);
    cmp({31'h0, irq}, 32'h0, "irq idle");
    meas(2'd2, -500);
    rchk(OFS_FLAG, 'h04);
    cmp({31'h0, irq}, 32'h1, "irq raised");
    rchk(OFS_IRQ_STAT, 'h04);
    meas(2'd2, -3500);
    rchk(OFS_COUNT + 8'h08, 2);
    wreg(OFS_IRQ_STAT, 'h04);
    cmp({31'h0, irq}, 32'h0, "irq cleared");
    wreg(OFS_IRQ_MASK, 'h00);
    meas(2'd2, 0);
    rchk(OFS_IRQ_STAT, 'h04);
    cmp({31'h0, irq}, 32'h0, "irq masked");
    wreg(OFS_IRQ_STAT, 'h04);
  endtask : t_fail

  task automatic t_sep;
    meas(2'd0, 30000);
    rchk(OFS_COUNT, 0);
    rchk(OFS_FLAG, 'h04);
    rchk(OFS_COUNT + 8'h0c, 0);
  endtask : t_sep

  task automatic t_sat;
    wreg(OFS_FLAG, 'h04);
    rchk(OFS_COUNT + 8'h08, 0);
    rchk(OFS_FLAG, 0);
    for (int i = 0; i < 9; i++) meas(2'd2, 100);
    rchk(OFS_COUNT + 8'h08, (1 << CW) - 1);
    rchk(OFS_FLAG, 'h04);
  endtask : t_sat

  task automatic t_outs;
    int vals[3] = '{100, -5000, -2000};
    logic ov;
    logic un;
    logic f;
    for (int k = 1; k < 4; k++) begin
      for (int p = 0; p < 2; p++) begin
        pol1 <= p[0];
        wreg(OFS_OUT0, 'h11 | (p << 1) | (k << 2));
        for (int j = 0; j < 3; j++) begin
          meas(2'd2, vals[j]);
          ov = (j == 0);
          un = (j == 1);
          f = (ov & k[0]) | (un & k[1]);
          cmp({31'h0, out1}, {31'h0, p[0] ? f : ~f}, "out one");
          cmp({31'h0, out2}, 32'h0, "out two off");
        end
      end
    end
    // each polarity switch ahead of its config write shows as an onset too
    cmp({24'h0, onsets}, 32'hb, "alarm onsets");
    wreg(OFS_OUT1, 'h27);
    meas(2'd2, 100);
    cmp({31'h0, out2}, 32'h0, "window two only");
    meas(2'd3, 25000);
    cmp({31'h0, out2}, 32'h1, "window two fail");
    wreg(OFS_OUT1, 'h17);
    meas(2'd3, 0);
    cmp({31'h0, out2}, 32'h1, "window one fail");
    wreg(OFS_OUT1, 'h37);
    cmp({31'h0, out2}, 32'h1, "either window");
    wreg(OFS_CTRL, 'h88);
    repeat (2) @(posedge clk);
    #1;
    cmp({31'h0, out2}, 32'h0, "checking off");
  endtask : t_outs

  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_units();
    t_fail();
    t_sep();
    t_sat();
    t_outs();
    close_out();
  end
endmodule : testbench
